// ==== rtl/fccr_pkg.sv ====
// Package: constants and types for the flash command configuration registers
package fccr_pkg;
    localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
    localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;
    localparam logic [7:0] CMD_SET_BURST_LEN = 8'hC0;
    localparam logic [7:0] CMD_RESUME_OR_CLR = 8'h30;
    localparam logic [7:0] CMD_LEGACY_RESET = 8'hF0;
    localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
    localparam logic [7:0] CMD_RESET_EXEC = 8'h99;
    // Register selectors carried with read/write-any commands
    localparam logic [1:0] SEL_CMD_BEH_BOOT = 2'h0;
    localparam logic [1:0] SEL_CMD_BEH_LIVE = 2'h1;
    localparam logic [1:0] SEL_WRAP_BOOT = 2'h2;
    localparam logic [1:0] SEL_WRAP_LIVE = 2'h3;
    // Field positions
    localparam int BIT_BLANK_SKIP = 5;
    localparam int BIT_PROG_WRAP = 4;
    localparam int BIT_SMALL_SECT = 3;
    localparam int BIT_RESUME_SEL = 2;
    localparam int BIT_LEGACY_RST = 0;
    localparam int BIT_WRAP_DIS = 4;
    // Writable masks, reserved bits read zero
    localparam logic [7:0] CMD_BEH_MASK = 8'h3D;
    localparam logic [7:0] CMD_BEH_LIVE_WMASK = 8'h35;
    localparam logic [7:0] WRAP_MASK = 8'hF3;
    // Values after reset
    localparam logic [7:0] CMD_BEH_BOOT_RST = 8'h00;
    localparam logic [7:0] WRAP_BOOT_RST = 8'h10;
    localparam logic [2:0] DRIVE_DEFAULT = 3'h0;
    localparam logic [2:0] DRIVE_DEFAULT_EQ = 3'h3;
    localparam logic [9:0] PAGE_WRAP_256 = 10'h0FF;
    localparam logic [9:0] PAGE_WRAP_512 = 10'h1FF;

    typedef enum logic [1:0] {
        FCCR_ERASE_NOW, FCCR_ERASE_SKIP, FCCR_ERASE_AFTER_CHECK
    } fccr_erase_e;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [1:0] reg_sel;
        logic [7:0] data;
    } fccr_cmd_s;

    typedef struct packed {
        logic blank_check_en;
        logic prog_wrap_512;
        logic small_sect_off;
        logic resume_on_30;
        logic wrap_en;
        logic [1:0] wrap_len;
        logic [2:0] drive_code;
    } fccr_cfg_s;
endpackage : fccr_pkg

// ==== rtl/fccr_regs.sv ====
// Configuration register bank for command behaviour and burst wrap
// Behaviour
// - Read-any 65h and write-any 71h reach all four configuration registers, boot and live.
// - Live bit 5 enables blank check before erase.
// - Blank check: failed previous erase means erase unconditionally.
// - Good previous erase: erase on first zero found, else skip.
// - Blank check covers parameter, sector and bulk erase.
// - Blank check off: every erase starts immediately.
// - Live bit 4 picks 512- or 256-byte page buffer wrap.
// - 256 mode: loading past location 255 wraps to zero.
// - Live bit 3 read-only: 1 uniform sectors, 0 hybrid 4 KB.
// - Enabled 4 KB sectors overlay top or bottom 32 KB range.
// - Live bit 2: 30h is resume when 1, clear status when 0.
// - Live bit 0 enables F0h software reset, else F0h ignored.
// - 66h followed by 99h always performs software reset.
// - Burst wrap affects main array reads only.
// - Reset copies boot burst-wrap register into live register.
// - Set-burst-length C0h also writes the live burst-wrap register.
// - Boot bits 7:5 drive strength; 000 equals 011.
// - Boot bit 4 is wrap disable, default 1.
// - Wrap applies only to quad I/O and DDR quad I/O reads.
// - Live command-behaviour register loads from boot copy on reset.
// - Each boot bit may be programmed to opposite state once.
`timescale 1ns/100ps
module fccr_regs
    import fccr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire fccr_cmd_s cmd_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic sw_reset_out,
    output logic resume_out,
    output logic clear_status_out,
    input wire logic erase_req_in,
    input wire logic prev_erase_ok_in,
    input wire logic zero_found_in,
    input wire logic scan_done_in,
    output logic erase_start_out,
    output logic erase_skip_out,
    output logic scan_req_out,
    input wire logic [9:0] load_addr_in,
    output logic [9:0] load_addr_out,
    input wire logic [1:0] addr_low_sel_in,
    output logic small_sect_top_out,
    input wire logic array_read_in,
    input wire logic quad_read_in,
    output logic wrap_active_out,
    output logic [6:0] wrap_bytes_out,
    output fccr_cfg_s cfg_out
);
    logic [7:0] beh_boot_reg, beh_boot_next;
    logic [7:0] beh_live_reg, beh_live_next;
    logic [7:0] wrap_boot_reg, wrap_boot_next;
    logic [7:0] wrap_live_reg, wrap_live_next;
    logic [7:0] boot_written_reg, boot_written_next;
    logic [7:0] wboot_written_reg, wboot_written_next;
    logic rst_armed_reg, rst_armed_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic sw_reset_reg, sw_reset_next;
    logic resume_reg, resume_next;
    logic clr_reg, clr_next;
    logic is_rd, is_wr, is_sbl;
    fccr_erase_e er_reg, er_next;
    logic scan_reg, scan_next;
    logic start_reg, start_next;
    logic skip_reg, skip_next;

    assign is_rd = cmd_in.valid && cmd_in.opcode == CMD_READ_ANY_REG;
    assign is_wr = cmd_in.valid && cmd_in.opcode == CMD_WRITE_ANY_REG;
    assign is_sbl = cmd_in.valid && cmd_in.opcode == CMD_SET_BURST_LEN;

    // One-time programming: only bits still at reset default may flip
    function automatic logic [7:0] otp_update(input logic [7:0] cur,
            input logic [7:0] dflt, input logic [7:0] done,
            input logic [7:0] wr, input logic [7:0] mask);
        logic [7:0] change;
        change = (wr ^ cur) & mask & ~done & ~(cur ^ dflt);
        otp_update = cur ^ change;
    endfunction : otp_update

    always_comb begin
        beh_boot_next = beh_boot_reg;
        wrap_boot_next = wrap_boot_reg;
        boot_written_next = boot_written_reg;
        wboot_written_next = wboot_written_reg;
        beh_live_next = beh_live_reg;
        wrap_live_next = wrap_live_reg;
        rst_armed_next = rst_armed_reg;
        rd_data_next = rd_data_reg;
        rd_valid_next = 1'b0;
        sw_reset_next = 1'b0;
        resume_next = 1'b0;
        clr_next = 1'b0;
        if (is_wr) begin
            case (cmd_in.reg_sel)
                SEL_CMD_BEH_BOOT: begin
                    beh_boot_next = otp_update(beh_boot_reg,
                        CMD_BEH_BOOT_RST, boot_written_reg,
                        cmd_in.data, CMD_BEH_MASK);
                    boot_written_next = boot_written_reg |
                        (beh_boot_next ^ beh_boot_reg);
                end
                SEL_CMD_BEH_LIVE: begin
                    // Small-sector bit keeps its live value, copied from boot on reset
                    beh_live_next = (cmd_in.data & CMD_BEH_LIVE_WMASK) |
                        (beh_live_reg & ~CMD_BEH_LIVE_WMASK);
                end
                SEL_WRAP_BOOT: begin
                    wrap_boot_next = otp_update(wrap_boot_reg,
                        WRAP_BOOT_RST, wboot_written_reg,
                        cmd_in.data, WRAP_MASK);
                    wboot_written_next = wboot_written_reg |
                        (wrap_boot_next ^ wrap_boot_reg);
                end
                default: begin
                    wrap_live_next = cmd_in.data & WRAP_MASK;
                end
            endcase
        end
        if (is_sbl) begin
            wrap_live_next = cmd_in.data & WRAP_MASK;
        end
        if (is_rd) begin
            rd_valid_next = 1'b1;
            case (cmd_in.reg_sel)
                SEL_CMD_BEH_BOOT: rd_data_next = beh_boot_reg;
                SEL_CMD_BEH_LIVE: rd_data_next = beh_live_reg;
                SEL_WRAP_BOOT: rd_data_next = wrap_boot_reg;
                default: rd_data_next = wrap_live_reg;
            endcase
        end
        if (cmd_in.valid) begin
            rst_armed_next = cmd_in.opcode == CMD_RESET_ENABLE;
            if (cmd_in.opcode == CMD_RESET_EXEC && rst_armed_reg) begin
                sw_reset_next = 1'b1;
            end
            if (cmd_in.opcode == CMD_LEGACY_RESET &&
                    beh_live_reg[BIT_LEGACY_RST]) begin
                sw_reset_next = 1'b1;
            end
            if (cmd_in.opcode == CMD_RESUME_OR_CLR) begin
                resume_next = beh_live_reg[BIT_RESUME_SEL];
                clr_next = ~beh_live_reg[BIT_RESUME_SEL];
            end
        end
        if (sw_reset_reg) begin
            beh_live_next = beh_boot_reg;
            wrap_live_next = wrap_boot_reg;
            rst_armed_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            beh_boot_reg <= CMD_BEH_BOOT_RST;
            wrap_boot_reg <= WRAP_BOOT_RST;
            boot_written_reg <= 8'h00;
            wboot_written_reg <= 8'h00;
            beh_live_reg <= CMD_BEH_BOOT_RST;
            wrap_live_reg <= WRAP_BOOT_RST;
            rst_armed_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            sw_reset_reg <= 1'b0;
            resume_reg <= 1'b0;
            clr_reg <= 1'b0;
        end else begin
            beh_boot_reg <= beh_boot_next;
            wrap_boot_reg <= wrap_boot_next;
            boot_written_reg <= boot_written_next;
            wboot_written_reg <= wboot_written_next;
            beh_live_reg <= beh_live_next;
            wrap_live_reg <= wrap_live_next;
            rst_armed_reg <= rst_armed_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            sw_reset_reg <= sw_reset_next;
            resume_reg <= resume_next;
            clr_reg <= clr_next;
        end
    end

    // Erase sequencing with optional blank check
    always_comb begin
        er_next = er_reg;
        scan_next = 1'b0;
        start_next = 1'b0;
        skip_next = 1'b0;
        case (er_reg)
            FCCR_ERASE_NOW: begin
                if (erase_req_in) begin
                    if (!beh_live_reg[BIT_BLANK_SKIP] || !prev_erase_ok_in)
                    begin
                        start_next = 1'b1;
                    end else begin
                        scan_next = 1'b1;
                        er_next = FCCR_ERASE_AFTER_CHECK;
                    end
                end
            end
            FCCR_ERASE_AFTER_CHECK: begin
                scan_next = 1'b1;
                if (zero_found_in) begin
                    start_next = 1'b1;
                    scan_next = 1'b0;
                    er_next = FCCR_ERASE_NOW;
                end else if (scan_done_in) begin
                    skip_next = 1'b1;
                    scan_next = 1'b0;
                    er_next = FCCR_ERASE_NOW;
                end
            end
            default: er_next = FCCR_ERASE_NOW;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || sw_reset_reg) begin
            er_reg <= FCCR_ERASE_NOW;
            scan_reg <= 1'b0;
            start_reg <= 1'b0;
            skip_reg <= 1'b0;
        end else begin
            er_reg <= er_next;
            scan_reg <= scan_next;
            start_reg <= start_next;
            skip_reg <= skip_next;
        end
    end

    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign sw_reset_out = sw_reset_reg;
    assign resume_out = resume_reg;
    assign clear_status_out = clr_reg;
    assign erase_start_out = start_reg;
    assign erase_skip_out = skip_reg;
    assign scan_req_out = scan_reg;

    // Page buffer load address wrap
    assign load_addr_out = load_addr_in & (beh_live_reg[BIT_PROG_WRAP] ?
        PAGE_WRAP_512 : PAGE_WRAP_256);

    // Parameter sector overlay: top when selected, absent when disabled
    assign small_sect_top_out = ~beh_live_reg[BIT_SMALL_SECT] &
        addr_low_sel_in[0];

    // Burst wrap applies to quad array reads only
    assign wrap_active_out = ~wrap_live_reg[BIT_WRAP_DIS] & array_read_in &
        quad_read_in;
    assign wrap_bytes_out = 7'h08 << wrap_live_reg[1:0];

    always_comb begin
        cfg_out.blank_check_en = beh_live_reg[BIT_BLANK_SKIP];
        cfg_out.prog_wrap_512 = beh_live_reg[BIT_PROG_WRAP];
        cfg_out.small_sect_off = beh_live_reg[BIT_SMALL_SECT];
        cfg_out.resume_on_30 = beh_live_reg[BIT_RESUME_SEL];
        cfg_out.wrap_en = ~wrap_live_reg[BIT_WRAP_DIS];
        cfg_out.wrap_len = wrap_live_reg[1:0];
        // Default code drives like the middle setting
        cfg_out.drive_code = (wrap_live_reg[7:5] == DRIVE_DEFAULT) ?
            DRIVE_DEFAULT_EQ : wrap_live_reg[7:5];
    end

    reset_copy_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sw_reset_reg |=> wrap_live_reg == $past(wrap_boot_reg))
        else $error("live wrap not reloaded");
    beh_copy_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sw_reset_reg |=> beh_live_reg == $past(beh_boot_reg))
        else $error("live behaviour not reloaded");
    seq_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (is_wr == 0 && cmd_in.valid && cmd_in.opcode == CMD_RESET_ENABLE)
        ##1 (cmd_in.valid && cmd_in.opcode == CMD_RESET_EXEC) |=> sw_reset_reg)
        else $error("66h 99h reset missed");
    legacy_rst_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (cmd_in.valid && cmd_in.opcode == CMD_LEGACY_RESET)
        |=> sw_reset_reg == $past(beh_live_reg[BIT_LEGACY_RST]) ||
            $past(rst_armed_reg))
        else $error("F0h handling wrong");
    resume_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (cmd_in.valid && cmd_in.opcode == CMD_RESUME_OR_CLR)
        |=> resume_reg == $past(beh_live_reg[BIT_RESUME_SEL]) &&
            clr_reg != resume_reg)
        else $error("30h decode wrong");
    no_check_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (er_reg == FCCR_ERASE_NOW && erase_req_in &&
         !beh_live_reg[BIT_BLANK_SKIP] && !sw_reset_reg)
        |=> start_reg && !scan_reg)
        else $error("erase not immediate");
    rd_answer_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        is_rd |=> rd_valid_reg ##1 !rd_valid_reg || $past(is_rd))
        else $error("read answer missing");
    reserved_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (beh_live_reg & ~CMD_BEH_MASK) == 8'h00 &&
        (wrap_live_reg & ~WRAP_MASK) == 8'h00)
        else $error("reserved bit set");
    wrap256_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !beh_live_reg[BIT_PROG_WRAP] |-> load_addr_out[9:8] == 2'b00)
        else $error("page wrap 256 broken");
endmodule : fccr_regs

// ==== testbench/fccr_host_model.sv ====
// Host model that issues decoded flash commands to the register bank
`timescale 1ns/100ps
module fccr_host_model
    import fccr_pkg::*;
(
    input wire logic sys_clk_in,
    output fccr_cmd_s cmd_out
);
    logic boot_small_reg;
    initial begin
        cmd_out = '0;
        boot_small_reg = 1'b0;
    end
    // Drives one command from a falling edge, held until the next issue or idle
    task automatic issue(input logic [7:0] op, input logic [1:0] sel,
                         input logic [7:0] dt);
        logic [7:0] d;
        d = dt;
        if (op == CMD_WRITE_ANY_REG && sel == SEL_CMD_BEH_LIVE) begin
            d[BIT_SMALL_SECT] = boot_small_reg;
        end
        if (op == CMD_WRITE_ANY_REG && sel == SEL_CMD_BEH_BOOT) begin
            boot_small_reg = boot_small_reg | dt[BIT_SMALL_SECT];
        end
        @(negedge sys_clk_in);
        cmd_out <= '{1'b1, op, sel, d};
    endtask : issue
    // Idle bus shows inverted leftovers, not the last command
    task automatic idle();
        @(negedge sys_clk_in);
        cmd_out <= '{1'b0, ~cmd_out.opcode, ~cmd_out.reg_sel, ~cmd_out.data};
    endtask : idle
endmodule : fccr_host_model

// ==== testbench/tb_fccr_regs.sv ====
// Self-checking testbench for the configuration register bank
`timescale 1ns/100ps
module tb_fccr_regs
    import fccr_pkg::*;
;
    logic sys_clk_in, rst_in, erase_req, prev_ok, zero_found, scan_done;
    logic array_rd, quad_rd, rd_valid, sw_reset, resume, clr_stat;
    logic e_start, e_skip, scan_req, small_top, wrap_act;
    logic [9:0] load_addr, load_out, la_exp;
    logic [1:0] low_sel;
    logic [7:0] rd_data, rv, d, last_rd;
    logic [6:0] wrap_bytes;
    fccr_cmd_s cmd;
    fccr_cfg_s cfg;
    int error_cnt, total_checks;
    logic [9:0] cnt [6];
    wire [5:0] pulses = {rd_valid, sw_reset, resume, clr_stat,
                         e_start, e_skip};

    fccr_host_model i_host (.sys_clk_in(sys_clk_in), .cmd_out(cmd));
    fccr_regs i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_in(cmd),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .sw_reset_out(sw_reset), .resume_out(resume),
        .clear_status_out(clr_stat), .erase_req_in(erase_req),
        .prev_erase_ok_in(prev_ok), .zero_found_in(zero_found),
        .scan_done_in(scan_done), .erase_start_out(e_start),
        .erase_skip_out(e_skip), .scan_req_out(scan_req),
        .load_addr_in(load_addr), .load_addr_out(load_out),
        .addr_low_sel_in(low_sel), .small_sect_top_out(small_top),
        .array_read_in(array_rd), .quad_read_in(quad_rd),
        .wrap_active_out(wrap_act), .wrap_bytes_out(wrap_bytes),
        .cfg_out(cfg));

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // Counts every pulse seen at settled falling edges
    always @(negedge sys_clk_in) begin
        for (int b = 0; b < 6; b++) if (pulses[b] === 1'b1) cnt[b]++;
        if (rd_valid === 1'b1) last_rd = rd_data;
    end

    task automatic chk(input string n, input logic [9:0] e,
                       input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Expected decoded configuration from the two live register values
    function automatic fccr_cfg_s exp_cfg(input logic [7:0] b,
                                          input logic [7:0] w);
        exp_cfg = '{b[5], b[4], b[3], b[2], ~w[4], w[1:0],
                    (w[7:5] == 3'h0) ? 3'h3 : w[7:5]};
    endfunction : exp_cfg
    task automatic tend(input string n);
        $display("Test %s done", n);
    endtask : tend
    task automatic send(input logic [7:0] op, input logic [1:0] sel,
                        input logic [7:0] dt);
        cnt = '{default: 0};
        i_host.issue(op, sel, dt);
        i_host.idle();
        repeat (3) @(negedge sys_clk_in);
    endtask : send
    task automatic rd(input logic [1:0] sel, output logic [7:0] v);
        send(CMD_READ_ANY_REG, sel, 8'h00);
        v = last_rd;
        chk("rd_valid", 10'h001, cnt[5]);
    endtask : rd
    task automatic sw_seq();
        cnt = '{default: 0};
        i_host.issue(CMD_RESET_ENABLE, 2'h0, 8'h00);
        i_host.issue(CMD_RESET_EXEC, 2'h0, 8'h00);
        i_host.idle();
        repeat (3) @(negedge sys_clk_in);
        chk("sw_reset", 10'h001, cnt[4]);
    endtask : sw_seq
    task automatic erase(input logic ok, input logic scan, input logic zero,
                         input logic st);
        cnt = '{default: 0};
        @(negedge sys_clk_in);
        erase_req = 1'b1;
        prev_ok = ok;
        @(negedge sys_clk_in);
        erase_req = 1'b0;
        chk("scan_req", scan, scan_req);
        @(negedge sys_clk_in);
        zero_found = scan & zero;
        scan_done = scan & ~zero;
        @(negedge sys_clk_in);
        zero_found = 1'b0;
        scan_done = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        chk("erase_start", st, cnt[1]);
        chk("erase_skip", !st, cnt[0]);
    endtask : erase
    task automatic test_done();
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        {rst_in, erase_req, prev_ok, zero_found, scan_done} = 5'h10;
        {array_rd, quad_rd} = 2'h0;
        load_addr = 10'h000;
        low_sel = 2'h0;
        error_cnt = 0;
        total_checks = 0;
        d = 8'($urandom(23430));
        repeat (2) @(negedge sys_clk_in);
        rst_in = 1'b0;
        rd(SEL_CMD_BEH_BOOT, rv);
        chk("beh_boot", 10'h000, rv);
        rd(SEL_CMD_BEH_LIVE, rv);
        chk("beh_live", 10'h000, rv);
        rd(SEL_WRAP_BOOT, rv);
        chk("wrap_boot", 10'h010, rv);
        rd(SEL_WRAP_LIVE, rv);
        chk("wrap_live", 10'h010, rv);
        chk("drive", 10'h003, cfg.drive_code);
        tend("reset");
        repeat (4) begin
            d = 8'($urandom);
            send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_LIVE, d);
            rd(SEL_CMD_BEH_LIVE, rv);
            chk("beh_live", d & 8'h35, rv);
        end
        tend("live_rw");
        for (int m = 0; m < 2; m++) begin
            send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_LIVE, m ? 8'h04 : 8'h00);
            send(CMD_RESUME_OR_CLR, 2'h0, 8'h00);
            chk("resume", 10'(m), cnt[3]);
            chk("clear", !m, cnt[2]);
            send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_LIVE, m ? 8'h01 : 8'h00);
            send(CMD_LEGACY_RESET, 2'h0, 8'h00);
            chk("sw_reset", 10'(m), cnt[4]);
        end
        rd(SEL_CMD_BEH_LIVE, rv);
        chk("beh_live", 10'h000, rv);
        send(CMD_RESET_EXEC, 2'h0, 8'h00);
        chk("sw_reset", 10'h000, cnt[4]);
        sw_seq();
        tend("commands");
        for (int n = 0; n < 4; n++) begin
            d = {3'($urandom), 5'(n)};
            if (n % 2) send(CMD_SET_BURST_LEN, SEL_WRAP_LIVE, d);
            else send(CMD_WRITE_ANY_REG, SEL_WRAP_LIVE, d);
            chk("wrap_bytes", 7'h08 << n, wrap_bytes);
            chk("cfg", exp_cfg(8'h00, d), cfg);
            for (int k = 0; k < 4; k++) begin
                array_rd = k[0];
                quad_rd = k[1];
                @(negedge sys_clk_in);
                chk("wrap_act", k == 3, wrap_act);
            end
        end
        send(CMD_SET_BURST_LEN, SEL_WRAP_LIVE, 8'h10);
        #1;
        chk("wrap_act", 10'h000, wrap_act);
        tend("wrap");
        for (int m = 0; m < 2; m++) begin
            send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_LIVE, m ? 8'h10 : 8'h00);
            load_addr = 10'($urandom);
            low_sel = 2'(m);
            #1;
            la_exp = load_addr & (m ? 10'h1FF : 10'h0FF);
            chk("load_addr", la_exp, load_out);
            chk("small_top", 10'(m), small_top);
        end
        tend("page");
        send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_BOOT, 8'h2C);
        send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_BOOT, 8'h00);
        rd(SEL_CMD_BEH_BOOT, rv);
        chk("beh_boot", 10'h02C, rv);
        send(CMD_WRITE_ANY_REG, SEL_WRAP_BOOT, 8'h63);
        sw_seq();
        rd(SEL_CMD_BEH_LIVE, rv);
        chk("beh_live", 10'h02C, rv);
        rd(SEL_WRAP_LIVE, rv);
        chk("wrap_live", 10'h063, rv);
        chk("drive", 10'h003, cfg.drive_code);
        chk("cfg", exp_cfg(8'h2C, 8'h63), cfg);
        chk("small_top", 10'h000, small_top);
        tend("boot");
        send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_LIVE, 8'h00);
        erase(1'b1, 1'b0, 1'b0, 1'b1);
        send(CMD_WRITE_ANY_REG, SEL_CMD_BEH_LIVE, 8'h20);
        erase(1'b0, 1'b0, 1'b0, 1'b1);
        erase(1'b1, 1'b1, 1'b1, 1'b1);
        erase(1'b1, 1'b1, 1'b0, 1'b0);
        tend("erase");
        test_done();
    end
endmodule : tb_fccr_regs
